// [core/dsos_top.sv]
// Drive status output selector: detection, selection, keypad watchdog
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Code 2: level window around run frequency
// - Code 3: accel reach, decel hysteresis hold
// - Code 4: inverted code 3 output
// - Level, band within limits; excess writes refused
// - Code 8: over-voltage trip by class
// - Code 9: under-voltage trip by class
// - Code 10: heatsink overheat flag
// - Code 11: analog or serial command lost
// - Code 12: run command and output on
// - Code 13: stopped without run command
// - Code 14: constant speed running
// - Code 16: waiting for run command
// - Code 17: fault per class mask
// - Mask 2: any trip except under-voltage
// - Code 18: fan alarm when not continuing
// - Code 19: external brake signal
// - Keypad failure routed by two bits
// - Keypad failure after continuous error time
// - Mask bits: undervolt, other, restart
// - Terminal and relay selected independently
module dsos_top
	import dsos_pkg::*;
#(
	parameter int unsigned KP_CYC = KP_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	// Drive state
	input wire logic [15:0] run_freq,
	input wire logic [15:0] preset_freq,
	input wire logic [9:0] dc_link_volts,
	input wire logic class_400v,
	input wire dsos_flags_s flags,
	// Keypad link
	input wire logic kp_frame_valid,
	input wire logic kp_link_err,
	// Outputs
	output logic open_collector_output,
	output logic relay_contact_output,
	output logic kp_fail_display
);

	// Watchdog counter width
	localparam int unsigned CW = 24;

	// Refuse timeouts the counter cannot hold
	if (KP_CYC < 1 || KP_CYC >= (1 << CW)) begin : g_bad_cyc
		$error("KP_CYC out of range");
	end

	localparam logic [CW-1:0] KP_LAST = CW'(KP_CYC - 1);

	// Configuration registers
	logic [15:0] level_q;
	logic [15:0] band_q;
	logic [15:0] maxf_q;
	logic [4:0] term_sel_q;
	logic [4:0] relay_sel_q;
	logic [2:0] mask_q;
	logic [1:0] route_q;
	logic fan_cont_q;
	// Detection state
	logic hyst_q;
	// Keypad watchdog
	dsos_kp_e kp_q;
	logic [CW-1:0] kp_cnt_q;
	logic kp_fail;
	// Output and read data registers
	logic oc_q;
	logic relay_q;
	logic [DW-1:0] rdata_q;
	// Combinational conditions
	logic [15:0] half_bw;
	logic win_det;
	logic fdt1_det;
	logic fdt2_det;
	logic hyst_low;
	logic ov_trip;
	logic uv_trip;
	logic fault_det;
	logic [19:0] conds;
	logic oc_d;
	logic relay_d;

	// Distance between two frequencies
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		absdiff = (a >= b) ? (a - b) : (b - a);
	endfunction

	// Picks one condition by selector code; unused codes stay low
	function automatic logic pick(input logic [4:0] code, input logic [19:0] c);
		pick = (code <= C_BRAKE) ? c[code] : 1'b0;
	endfunction

	// Frequency setting guard, against max and absolute limit
	function automatic logic freq_ok(input logic [15:0] v, input logic [15:0] mx);
		freq_ok = (v <= mx) && (v <= FREQ_LIMIT);
	endfunction

	// Half bandwidth
	assign half_bw = {1'b0, band_q[15:1]};

	assign win_det = absdiff(level_q, run_freq) <= half_bw;
	// Preset tracking windows
	assign fdt1_det = absdiff(preset_freq, run_freq) <= half_bw;
	assign fdt2_det = (preset_freq == level_q) && fdt1_det;
	// Lower hysteresis edge; never reached when it would be negative
	assign hyst_low = (level_q >= half_bw) && (run_freq <= level_q - half_bw);

	assign ov_trip = class_400v ? (dc_link_volts > OV_400) : (dc_link_volts > OV_200);
	assign uv_trip = class_400v ? (dc_link_volts < UV_400) : (dc_link_volts < UV_200);

	// fault class decode: bit 0 under-voltage, bit 2 retry
	// bit 1 covers every trip but under-voltage
	assign fault_det = (mask_q[0] && uv_trip) || (mask_q[2] && flags.restart_pending)
		|| (mask_q[1] && (ov_trip || flags.other_trip || flags.heatsink_overheat_flag));

	// Condition vector indexed by selector code
	always_comb begin
		conds = 20'h00000;
		conds[C_FDT1] = fdt1_det;
		conds[C_FDT2] = fdt2_det;
		conds[C_WIN] = win_det;
		conds[C_HYST] = hyst_q;
		conds[C_HYST_N] = ~hyst_q;
		conds[C_MOTOR_OL] = flags.motor_overload_flag;
		conds[C_INV_OL] = flags.inverter_overload_flag;
		conds[C_STALL] = flags.stall;
		conds[C_SEARCH] = flags.speed_search;
		conds[C_OV] = ov_trip;
		conds[C_UV] = uv_trip;
		conds[C_OH] = flags.heatsink_overheat_flag;
		conds[C_CMD_LOSS] = flags.analog_loss | flags.rs485_loss;
		conds[C_RUN] = flags.run_cmd & flags.inv_out_on;
		conds[C_STOP] = ~flags.run_cmd & ~flags.inv_out_on;
		conds[C_CONST] = flags.inv_out_on & ~flags.accel & ~flags.decel;
		conds[C_WAIT] = flags.wait_run;
		conds[C_FAULT] = fault_det;
		// fan alarm only when operation does not continue
		conds[C_FAN] = flags.fan_fault & ~fan_cont_q;
		conds[C_BRAKE] = flags.brake_en & flags.brake_sig;
	end

	// bit 0 terminal, bit 1 relay
	assign oc_d = pick(term_sel_q, conds) | (route_q[0] & kp_fail);
	assign relay_d = pick(relay_sel_q, conds) | (route_q[1] & kp_fail);

	// accel sets, decel clears at lower edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hyst_q <= 1'b0;
		end else if (flags.accel && run_freq >= level_q) begin
			// Reached level while speeding up
			hyst_q <= 1'b1;
		end else if (flags.decel && hyst_low) begin
			// Dropped to level minus half band
			hyst_q <= 1'b0;
		end
	end

	// Output registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			oc_q <= 1'b0;
			relay_q <= 1'b0;
		end else begin
			oc_q <= oc_d;
			relay_q <= relay_d;
		end
	end

	assign open_collector_output = oc_q;
	assign relay_contact_output = relay_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			kp_q <= KP_IDLE;
			kp_cnt_q <= '0;
		end else begin
			case (kp_q)
				// Link healthy
				KP_IDLE: begin
					kp_cnt_q <= '0;
					if (kp_link_err && !kp_frame_valid) begin
						kp_q <= KP_TIMING;
					end
				end
				// Error seen, counting
				KP_TIMING: begin
					if (kp_frame_valid || !kp_link_err) begin
						kp_q <= KP_IDLE;
						kp_cnt_q <= '0;
					end else if (kp_cnt_q >= KP_LAST) begin
						kp_q <= KP_FAILED;
					end else begin
						kp_cnt_q <= kp_cnt_q + 1'b1;
					end
				end
				// Failure held until a good frame
				KP_FAILED: begin
					kp_cnt_q <= '0;
					if (kp_frame_valid) begin
						kp_q <= KP_IDLE;
					end
				end
				default: begin
					kp_q <= KP_IDLE;
					kp_cnt_q <= '0;
				end
			endcase
		end
	end

	assign kp_fail = (kp_q == KP_FAILED);
	assign kp_fail_display = kp_fail;

	// Register writes
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_q <= LEVEL_RST;
			band_q <= BAND_RST;
			maxf_q <= MAXF_RST;
			term_sel_q <= TERM_SEL_RST;
			relay_sel_q <= RELAY_SEL_RST;
			mask_q <= MASK_RST;
			route_q <= ROUTE_RST;
			fan_cont_q <= FAN_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				A_LEVEL: begin
					if (freq_ok(reg_wdata, maxf_q)) begin
						level_q <= reg_wdata;
					end
				end
				A_BAND: begin
					if (freq_ok(reg_wdata, maxf_q)) begin
						band_q <= reg_wdata;
					end
				end
				// Max frequency, within absolute limit
				A_MAXF: begin
					if (reg_wdata <= FREQ_LIMIT) begin
						maxf_q <= reg_wdata;
					end
				end
				// Selectors; codes above range ignored per field
				A_SEL: begin
					if (reg_wdata[SEL_TERM_LSB +: 5] <= C_BRAKE) begin
						term_sel_q <= reg_wdata[SEL_TERM_LSB +: 5];
					end
					if (reg_wdata[SEL_RELAY_LSB +: 5] <= C_BRAKE) begin
						relay_sel_q <= reg_wdata[SEL_RELAY_LSB +: 5];
					end
				end
				// Mask, routing, fan behaviour
				A_CFG: begin
					mask_q <= reg_wdata[CFG_MASK_LSB +: 3];
					route_q <= reg_wdata[CFG_ROUTE_LSB +: 2];
					fan_cont_q <= reg_wdata[CFG_FAN_BIT];
				end
				// Read-only or unmapped
				default: begin
				end
			endcase
		end
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				A_LEVEL: rdata_q <= level_q;
				A_BAND: rdata_q <= band_q;
				A_MAXF: rdata_q <= maxf_q;
				A_SEL: rdata_q <= {3'h0, relay_sel_q, 3'h0, term_sel_q};
				A_CFG: rdata_q <= {7'h00, fan_cont_q, 2'h0, route_q, 1'h0, mask_q};
				A_STAT: rdata_q <= {8'h00, uv_trip, ov_trip, fault_det, kp_fail,
					hyst_q, win_det, relay_q, oc_q};
				default: rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

	// Window drives terminal
	property p_win;
		@(posedge clk) disable iff (sys_rst)
		(term_sel_q == C_WIN && !route_q[0]) |=> (oc_q == $past(win_det));
	endproperty
	a_win: assert property (p_win) else $error("window output wrong");
	// Accel reach sets hysteresis
	property p_hyst_set;
		@(posedge clk) disable iff (sys_rst)
		(flags.accel && run_freq >= level_q) |=> hyst_q;
	endproperty
	a_hyst_set: assert property (p_hyst_set) else $error("hysteresis not set");
	// Inverted hysteresis on relay
	property p_hyst_n;
		@(posedge clk) disable iff (sys_rst)
		(relay_sel_q == C_HYST_N && !route_q[1]) |=> (relay_q != $past(hyst_q));
	endproperty
	a_hyst_n: assert property (p_hyst_n) else $error("inverted output wrong");
	// Excess level refused
	property p_level_ref;
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr == A_LEVEL && reg_wdata > maxf_q) |=> $stable(level_q);
	endproperty
	a_level_ref: assert property (p_level_ref) else $error("level write not refused");
	// Over-voltage on 400 V class
	property p_ov;
		@(posedge clk) disable iff (sys_rst)
		(class_400v && dc_link_volts > OV_400 && term_sel_q == C_OV) |=> oc_q;
	endproperty
	a_ov: assert property (p_ov) else $error("over-voltage missed");
	// Stop indication
	property p_stop;
		@(posedge clk) disable iff (sys_rst)
		(term_sel_q == C_STOP && !flags.run_cmd && !flags.inv_out_on) |=> oc_q;
	endproperty
	a_stop: assert property (p_stop) else $error("stop output missed");
	// Mask 2 ignores under-voltage alone
	property p_mask2;
		@(posedge clk) disable iff (sys_rst)
		(relay_sel_q == C_FAULT && mask_q == 3'h2 && !route_q[1] && !ov_trip
			&& !flags.other_trip && !flags.heatsink_overheat_flag) |=> !relay_q;
	endproperty
	a_mask2: assert property (p_mask2) else $error("fault mask wrong");
	// Routed keypad failure reaches relay
	property p_route;
		@(posedge clk) disable iff (sys_rst)
		(kp_fail && route_q[1]) |=> relay_q;
	endproperty
	a_route: assert property (p_route) else $error("keypad routing wrong");
	// Failure only after an error
	property p_kp_rise;
		@(posedge clk) disable iff (sys_rst)
		$rose(kp_fail) |-> ($past(kp_link_err) && kp_cnt_q == KP_LAST);
	endproperty
	a_kp_rise: assert property (p_kp_rise) else $error("early keypad failure");
	// Valid frame clears failure
	property p_kp_clr;
		@(posedge clk) disable iff (sys_rst)
		kp_frame_valid |=> !kp_fail;
	endproperty
	a_kp_clr: assert property (p_kp_clr) else $error("failure not cleared");

	// Scenario coverage
	c_kp_fail: cover property (@(posedge clk) disable iff (sys_rst) $rose(kp_fail));
	c_hyst: cover property (@(posedge clk) disable iff (sys_rst) $fell(hyst_q));
	c_fault: cover property (@(posedge clk) disable iff (sys_rst)
		relay_sel_q == C_FAULT ##1 relay_q);

endmodule // dsos_top
`default_nettype wire

// [core/dsos_pkg.sv]
// Constants and carrier types for the drive status output selector
package dsos_pkg;
	// Register bus widths
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 4;
	// Register offsets
	localparam logic [3:0] A_LEVEL = 4'h0;
	localparam logic [3:0] A_BAND = 4'h1;
	localparam logic [3:0] A_MAXF = 4'h2;
	localparam logic [3:0] A_SEL = 4'h3;
	localparam logic [3:0] A_CFG = 4'h4;
	localparam logic [3:0] A_STAT = 4'h5;
	// Frequencies in 0.01 Hz units
	localparam logic [15:0] LEVEL_RST = 16'h0BB8;
	localparam logic [15:0] BAND_RST = 16'h03E8;
	localparam logic [15:0] MAXF_RST = 16'h1770;
	localparam logic [15:0] FREQ_LIMIT = 16'h9C40;
	// Selector reset values
	localparam logic [4:0] TERM_SEL_RST = 5'h0C;
	localparam logic [4:0] RELAY_SEL_RST = 5'h11;
	localparam logic [2:0] MASK_RST = 3'h2;
	localparam logic [1:0] ROUTE_RST = 2'h0;
	localparam logic FAN_RST = 1'h0;
	// Field positions
	localparam int unsigned SEL_TERM_LSB = 0;
	localparam int unsigned SEL_RELAY_LSB = 8;
	localparam int unsigned CFG_MASK_LSB = 0;
	localparam int unsigned CFG_ROUTE_LSB = 4;
	localparam int unsigned CFG_FAN_BIT = 8;
	// Selector codes
	localparam logic [4:0] C_FDT1 = 5'h00;
	localparam logic [4:0] C_FDT2 = 5'h01;
	localparam logic [4:0] C_WIN = 5'h02;
	localparam logic [4:0] C_HYST = 5'h03;
	localparam logic [4:0] C_HYST_N = 5'h04;
	localparam logic [4:0] C_MOTOR_OL = 5'h05;
	localparam logic [4:0] C_INV_OL = 5'h06;
	localparam logic [4:0] C_STALL = 5'h07;
	localparam logic [4:0] C_OV = 5'h08;
	localparam logic [4:0] C_UV = 5'h09;
	localparam logic [4:0] C_OH = 5'h0A;
	localparam logic [4:0] C_CMD_LOSS = 5'h0B;
	localparam logic [4:0] C_RUN = 5'h0C;
	localparam logic [4:0] C_STOP = 5'h0D;
	localparam logic [4:0] C_CONST = 5'h0E;
	localparam logic [4:0] C_SEARCH = 5'h0F;
	localparam logic [4:0] C_WAIT = 5'h10;
	localparam logic [4:0] C_FAULT = 5'h11;
	localparam logic [4:0] C_FAN = 5'h12;
	localparam logic [4:0] C_BRAKE = 5'h13;
	// DC link trip thresholds in volts
	localparam logic [9:0] OV_200 = 10'h190;
	localparam logic [9:0] OV_400 = 10'h334;
	localparam logic [9:0] UV_200 = 10'h0B4;
	localparam logic [9:0] UV_400 = 10'h168;
	// Keypad link timeout
	localparam int unsigned KP_TIMEOUT_US = 1000;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned KP_TIMEOUT_CYC = KP_TIMEOUT_US * CLK_MHZ;
	// Drive status flags from the controller
	typedef struct packed {
		logic accel;
		logic decel;
		logic run_cmd;
		logic inv_out_on;
		logic motor_overload_flag;
		logic inverter_overload_flag;
		logic stall;
		logic speed_search;
		logic wait_run;
		logic heatsink_overheat_flag;
		logic analog_loss;
		logic rs485_loss;
		logic other_trip;
		logic restart_pending;
		logic fan_fault;
		logic brake_en;
		logic brake_sig;
	} dsos_flags_s;
	// Keypad link watchdog states
	typedef enum logic [1:0] {KP_IDLE, KP_TIMING, KP_FAILED} dsos_kp_e;
endpackage

// [testbench/dsos_wiring_model.sv]
// Far-side wiring model: open-collector sink and relay contact pair
`timescale 1ns/1ps
`default_nettype none
module dsos_wiring_model (
	// Outputs of the selector
	input wire logic open_collector_output,
	input wire logic relay_contact_output,
	// Wiring as seen by the load
	output logic term_sinking,
	output logic contact_no_closed,
	output logic contact_nc_closed
);
	// Transistor sinks current while the terminal is active
	assign term_sinking = open_collector_output;
	// Energised coil closes the normally-open side and opens the other
	assign contact_no_closed = relay_contact_output;
	assign contact_nc_closed = !relay_contact_output;
endmodule // dsos_wiring_model
`default_nettype wire

// [testbench/dsos_top_tb.sv]
// Self-checking testbench for the drive status output selector
`timescale 1ns/1ps
`default_nettype none
module dsos_top_tb;
	import dsos_pkg::*;
	// Short keypad timeout keeps the run brief
	localparam int unsigned KPC = 8;
	logic clk, sys_rst, reg_wr, reg_rd, class_400v, kp_frame_valid, kp_link_err;
	logic [AW-1:0] reg_addr;
	logic [DW-1:0] reg_wdata, reg_rdata, rv;
	logic [15:0] run_freq, preset_freq;
	logic [9:0] dc_link_volts;
	dsos_flags_s flags, fl;
	logic oc, rc, kpd, t_sink, c_no, c_nc;
	int fail_count, cmp_count, seed, cyc, r, m, fb, lv, bw;
	// Expected reset contents of the five writable words
	logic [15:0] rtab [5] = '{16'h0BB8, 16'h03E8, MAXF_RST, 16'h110C, 16'h0002};
	// Hysteresis steps: accel, decel, frequency, expected; the first clears state
	int ha [6] = '{0, 1, 1, 0, 0, 0};
	int hd [6] = '{1, 0, 0, 0, 1, 1};
	int hf [6] = '{1000, 2999, 3000, 1000, 2501, 2500};
	int he [6] = '{0, 0, 1, 1, 1, 0};
	dsos_top #(.KP_CYC(KPC)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.run_freq(run_freq), .preset_freq(preset_freq), .dc_link_volts(dc_link_volts),
		.class_400v(class_400v), .flags(flags), .kp_frame_valid(kp_frame_valid),
		.kp_link_err(kp_link_err), .open_collector_output(oc), .relay_contact_output(rc),
		.kp_fail_display(kpd));
	dsos_wiring_model wiring (.open_collector_output(oc), .relay_contact_output(rc),
		.term_sinking(t_sink), .contact_no_closed(c_no), .contact_nc_closed(c_nc));
	// Clock generator, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Closing report
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict;
		end
	end
	// Compare and report
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Let registered outputs follow the inputs
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	// Reference condition for one selector code
	function automatic logic model(input int c);
		int w, ww;
		logic ov, uv;
		w = (preset_freq > run_freq) ? preset_freq - run_freq : run_freq - preset_freq;
		ww = (lv > run_freq) ? lv - run_freq : run_freq - lv;
		ov = class_400v ? (dc_link_volts > 820) : (dc_link_volts > 400);
		uv = class_400v ? (dc_link_volts < 360) : (dc_link_volts < 180);
		case (c)
			0: return w <= bw / 2;
			1: return (w <= bw / 2) && (preset_freq == lv);
			2: return ww <= bw / 2;
			5: return flags.motor_overload_flag;
			6: return flags.inverter_overload_flag;
			7: return flags.stall;
			8: return ov;
			9: return uv;
			10: return flags.heatsink_overheat_flag;
			11: return flags.analog_loss || flags.rs485_loss;
			12: return flags.run_cmd && flags.inv_out_on;
			13: return !flags.run_cmd && !flags.inv_out_on;
			14: return flags.inv_out_on && !flags.accel && !flags.decel;
			15: return flags.speed_search;
			16: return flags.wait_run;
			17: return (m[0] && uv) || (m[2] && flags.restart_pending) ||
				(m[1] && (ov || flags.other_trip || flags.heatsink_overheat_flag));
			18: return flags.fan_fault && fb == 0;
			19: return flags.brake_en && flags.brake_sig;
			default: return 1'b0;
		endcase
	endfunction
	// Main sequence
	initial begin
		seed = 74;
		lv = 3000;
		bw = 1000;
		sys_rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, run_freq, preset_freq} = '0;
		{dc_link_volts, class_400v, kp_frame_valid, kp_link_err} = '0;
		flags = '0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset contents and refused writes
		for (int i = 0; i < 5; i++) begin
			rd(4'(i), rv);
			chk("reset word", rtab[i], rv);
		end
		rd(4'hF, rv);
		chk("unmapped", 16'h0000, rv);
		wr(A_LEVEL, 16'd6001);
		rd(A_LEVEL, rv);
		chk("level over max", 16'h0BB8, rv);
		wr(A_BAND, 16'd6000);
		rd(A_BAND, rv);
		chk("band at max", 16'h1770, rv);
		wr(A_BAND, 16'h03E8);
		wr(A_SEL, 16'h1414);
		rd(A_SEL, rv);
		chk("selector over 19", 16'h110C, rv);
		$display("register test done");
		// Every selector code but 3 and 4 on the terminal, and all but 3, 4, 15 and 16 on the relay, against random drive state
		for (int c = 0; c < 20; c++) begin
			if (c == 3 || c == 4) begin
				continue;
			end
			r = (c == 15 || c == 16) ? 17 : 19 - c;
			m = c % 8;
			fb = c % 2;
			wr(A_SEL, 16'(r * 256 + c));
			wr(A_CFG, 16'(fb * 256 + m));
			for (int k = 0; k < 4; k++) begin
				@(posedge clk);
				run_freq <= 16'(2000 + $unsigned($random(seed)) % 2000);
				preset_freq <= (k == 0) ? 16'h0BB8 : 16'(2000 + $unsigned($random(seed)) % 2000);
				// Trip thresholds crossed on purpose in two of the four steps
				dc_link_volts <= (k == 1) ? OV_400 + 10'h001 :
					(k == 2) ? UV_200 - 10'h001 : 10'($random(seed));
				class_400v <= k[0];
				// All flags low once, so the stop condition is always reached
				flags <= (k == 0) ? 17'h00000 : 17'($random(seed));
				settle;
				chk("terminal", 16'(model(c)), 16'(t_sink));
				chk("relay", 16'(model(r)), 16'(c_no));
				chk("relay nc", 16'(!model(r)), 16'(c_nc));
			end
		end
		$display("selector code test done");
		// Level hysteresis, plain on terminal and inverted on relay
		wr(A_SEL, 16'h0403);
		wr(A_CFG, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			fl = '0;
			fl.accel = ha[i][0];
			fl.decel = hd[i][0];
			flags <= fl;
			run_freq <= 16'(hf[i]);
			settle;
			chk("hysteresis", 16'(he[i]), 16'(oc));
			chk("inverted hysteresis", 16'(!he[i]), 16'(rc));
		end
		$display("hysteresis test done");
		// Keypad link failure routed to the relay only
		wr(A_SEL, 16'h0C0D);
		wr(A_CFG, 16'h0020);
		@(posedge clk);
		fl = '0;
		fl.run_cmd = 1'b1;
		flags <= fl;
		kp_link_err <= 1'b1;
		repeat (KPC) @(posedge clk);
		#1 chk("early failure", 16'h0000, 16'(kpd));
		repeat (6) @(posedge clk);
		#1 chk("failure shown", 16'h0001, 16'(kpd));
		chk("relay routed", 16'h0001, 16'(rc));
		chk("terminal not routed", 16'h0000, 16'(oc));
		@(posedge clk);
		kp_link_err <= 1'b0;
		settle;
		chk("failure held", 16'h0001, 16'(kpd));
		@(posedge clk);
		kp_frame_valid <= 1'b1;
		@(posedge clk);
		kp_frame_valid <= 1'b0;
		settle;
		chk("failure cleared", 16'h0000, 16'(kpd));
		chk("relay released", 16'h0000, 16'(rc));
		// Frame in mid-count restarts the timer
		@(posedge clk);
		kp_link_err <= 1'b1;
		repeat (6) @(posedge clk);
		kp_frame_valid <= 1'b1;
		@(posedge clk);
		kp_frame_valid <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk("timer restarted", 16'h0000, 16'(kpd));
		// Error held on reaches failure, visible in the status word
		repeat (6) @(posedge clk);
		#1 chk("failure after restart", 16'h0001, 16'(kpd));
		rd(A_STAT, rv);
		chk("status failure bits", 16'h0012, rv & 16'h0013);
		$display("keypad test done");
		// Reset in mid-run clears outputs and restores the selectors
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1 chk("outputs after reset", 16'h0000, 16'({oc, rc, kpd}));
		rd(A_SEL, rv);
		chk("selectors after reset", 16'h110C, rv);
		$display("reset test done");
		give_verdict;
	end
endmodule // dsos_top_tb
`default_nettype wire
